/* File: rtl/cvd_defines.svh */
`ifndef CVD_DEFINES_SVH
`define CVD_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define OFS_CTRL0 8'h00
`define OFS_CTRL1 8'h04
`define OFS_PRE 8'h08
`define OFS_ACQ 8'h0c
`define OFS_PUMP 8'h10
`define OFS_STAT 8'h14
`define OFS_CHAN 8'h18
`define B_ON 0
`define B_START 1
`define B_CONTINUOUS_SELECT 2
`define B_DBL 3
`define B_PRECHARGE_POLARITY 0
`define B_GPOL 1
`define B_INV 2
`define B_PUMP_EN 0
`define B_PUMP_RDY 1
`define B_DONE 0
`define B_BUSY 1
`define B_SECOND 2
`define RST_PRE 8'h00
`define RST_ACQ 13'h0000
`define RST_CHAN 6'h00
`define RST_OE_N 1'b1
`define ACQ_MAX_CYC 13'h1fff
`define CONV_CYC 13'h000f
`define PUMP_START_NS 1000
`define PUMP_START_CYC ((`PUMP_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: rtl/cvd_pkg.sv */
package cvd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRE = 2'b01,
        ST_ACQ = 2'b11,
        ST_CONV = 2'b10
    } stage_t;

    typedef struct packed {
        stage_t st;
        logic on;
        logic start;
        logic continuous_select;
        logic dbl;
        logic precharge_polarity;
        logic gpol;
        logic inv;
        logic [7:0] pre;
        logic [12:0] acq;
        logic pump_en;
        logic done;
        logic [5:0] chan;
        logic dirty;
        logic second;
        logic pol;
        logic ga;
        logic gb;
        logic ld;
        logic [12:0] len;
        logic hold_pre;
        logic pin_lvl;
        logic oe_n;
        logic connect;
        logic convert;
        logic ack;
        logic [31:0] dat;
    } ctl_t;

    typedef struct packed {
        logic [12:0] cnt;
    } tmr_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic rdy;
    } pump_t;
endpackage

/* File: rtl/cvd_if.sv */
`timescale 1ns/1ps
interface stage_if;
    logic ld;
    logic [12:0] len;
    logic done;
    modport ctrl (output ld, output len, input done);
    modport tmr (input ld, input len, output done);
endinterface

interface pump_if;
    logic en;
    logic rdy;
    modport ctrl (output en, input rdy);
    modport pump (input en, output rdy);
endinterface

/* File: rtl/stage_timer.sv */
`timescale 1ns/1ps
`include "cvd_defines.svh"
module stage_timer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // stage control
    stage_if.tmr tif
);
    cvd_pkg::tmr_t s_q;
    cvd_pkg::tmr_t s_d;

    // a stage lasts len cycles: done marks its last cycle
    assign tif.done = (s_q.cnt == 13'h0001);

    always_comb begin
        s_d = s_q;
        if (tif.ld) begin
            s_d.cnt = tif.len;
        end else if (s_q.cnt != 13'h0000) begin
            s_d.cnt = s_q.cnt - 13'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    load_len_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i) tif.ld |=> s_q.cnt == $past(tif.len))
        else $error("timer did not load stage length");
    count_down_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (!tif.ld && s_q.cnt != 13'h0000) |=> s_q.cnt == $past(s_q.cnt) - 13'h0001)
        else $error("timer did not count down by one");
endmodule

/* File: rtl/pump_ready.sv */
`timescale 1ns/1ps
`include "cvd_defines.svh"
module pump_ready (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pump control
    pump_if.pump pif
);
    localparam logic [15:0] CNT_LAST = 16'(`PUMP_START_CYC - 1);
    cvd_pkg::pump_t s_q;
    cvd_pkg::pump_t s_d;

    assign pif.rdy = s_q.rdy;

    always_comb begin
        s_d = s_q;
        if (!pif.en) begin
            s_d = '0;
        end else if (!s_q.rdy) begin
            if (s_q.cnt == CNT_LAST) begin
                s_d.rdy = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ready_late_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(s_q.rdy) |-> $past(pif.en) && s_q.cnt == CNT_LAST)
        else $error("pump ready before start-up time");
    ready_drop_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i) !pif.en |=> !s_q.rdy)
        else $error("pump ready while pump off");
endmodule

/* File: rtl/cvd_sequencer.sv */
`timescale 1ns/1ps
`include "cvd_defines.svh"
// Functional notes
// - Precharge is used only when the precharge time is non-zero.
// - Precharge begins on software start, trigger or computation restart.
// - Zero precharge time at conversion start skips the precharge stage.
// - In precharge the hold cap is detached and tied per precharge polarity.
// - In precharge the channel pin drives a digital level from the polarity.
// - The sensor path is precharged opposite to the hold cap.
// - Precharge pin drive overrides the pin direction setting.
// - Precharge length is timed from the precharge time register.
// - Acquisition follows start or precharge and is timed by its register.
// - Acquisition releases the pin drive and connects channel to hold cap.
// - With precharge, zero acquisition time means 8191 cycles.
// - Without precharge, zero acquisition time skips acquisition unless the channel changed.
// - After a channel change an acquisition completes before conversion.
// - The hold cap is never discharged between conversions.
// - Differential mode repeats the sequence with inverted precharge levels.
// - Pump enable starts pump; ready only after start-up time.
// - First precharge drives both guard outputs to guard polarity.
// - Acquisition inverts first guard output; second keeps its level.
// - With invert bit, second precharge guards opposite, first toggles again.
// - Completion clears start unless continuous, and sets the done flag.
module cvd_sequencer #(
    parameter logic [12:0] ACQ_MAX = `ACQ_MAX_CYC
) (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESETN_I,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // conversion starts
    input wire logic TRIGGER_I,
    input wire logic RESTART_I,
    // analog front end
    output logic [5:0] CHANNEL_O,
    output logic HOLD_PRECHARGE_O,
    output logic HOLD_LEVEL_O,
    output logic CHANNEL_CONNECT_O,
    output logic CONVERT_O,
    // channel pin
    output logic PIN_OUT_O,
    output logic PIN_OE_N_O,
    // guard rings
    output logic GUARD_FIRST_O,
    output logic GUARD_SECOND_O,
    // charge pump and status
    output logic PUMP_ON_O,
    output logic PUMP_READY_O,
    output logic DONE_O
);
    cvd_pkg::ctl_t s_q;
    cvd_pkg::ctl_t s_d;
    logic wr;
    logic set_done;
    logic [15:0] acq_w;

    stage_if t_if ();
    pump_if p_if ();

    stage_timer u_tmr (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .tif(t_if)
    );

    pump_ready u_pump (
        .clk_i(CLK_I),
        .rst_n_i(RESETN_I),
        .pif(p_if)
    );

    assign t_if.ld = s_d.ld;
    assign t_if.len = s_d.len;
    assign p_if.en = s_q.pump_en;

    // byte-lane merge for the two low lanes
    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = nw[7:0];
        end
        if (sel[1]) begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    // acquisition length, zero selects the longest stage
    function automatic logic [12:0] acq_len(input logic [12:0] acq, input logic [12:0] amax);
        return (acq == 13'h0000) ? amax : acq;
    endfunction

    // opens one sample: precharge, else acquisition, else conversion
    function automatic cvd_pkg::ctl_t begin_sample(input cvd_pkg::ctl_t c, input logic sec,
                                                   input logic [12:0] amax);
        cvd_pkg::ctl_t r;
        logic g;
        r = c;
        g = c.gpol ^ (sec & c.inv);
        r.second = sec;
        r.pol = c.precharge_polarity ^ sec;
        r.ga = g;
        r.gb = g;
        r.ld = 1'b1;
        if (c.pre != 8'h00) begin
            r.st = cvd_pkg::ST_PRE;
            r.len = {5'h00, c.pre};
        end else if (c.acq != 13'h0000 || c.dirty) begin
            r.st = cvd_pkg::ST_ACQ;
            r.len = acq_len(c.acq, amax);
            r.ga = ~g;
        end else begin
            r.st = cvd_pkg::ST_CONV;
            r.len = `CONV_CYC;
        end
        return r;
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.ld = 1'b0;
        s_d.len = 13'h0000;
        set_done = 1'b0;
        acq_w = lane16({3'h0, s_q.acq}, DAT_I[15:0], SEL_I[1:0]);
        wr = CYC_I & STB_I & WE_I & s_q.ack;
        s_d.ack = CYC_I & STB_I & ~s_q.ack;
        s_d.dat = 32'h0000_0000;

        case (s_q.st)
            cvd_pkg::ST_IDLE: begin
                if (s_q.on && (s_q.start || TRIGGER_I || RESTART_I)) begin
                    s_d = begin_sample(s_d, 1'b0, ACQ_MAX);
                    s_d.start = 1'b1;
                end
            end
            cvd_pkg::ST_PRE: begin
                if (t_if.done) begin
                    s_d.st = cvd_pkg::ST_ACQ;
                    s_d.ld = 1'b1;
                    s_d.len = acq_len(s_q.acq, ACQ_MAX);
                    s_d.ga = ~s_q.ga;
                end
            end
            cvd_pkg::ST_ACQ: begin
                if (t_if.done) begin
                    s_d.st = cvd_pkg::ST_CONV;
                    s_d.ld = 1'b1;
                    s_d.len = `CONV_CYC;
                    s_d.dirty = 1'b0;
                end
            end
            cvd_pkg::ST_CONV: begin
                if (t_if.done) begin
                    if (s_q.dbl && !s_q.second) begin
                        s_d = begin_sample(s_d, 1'b1, ACQ_MAX);
                    end else begin
                        set_done = 1'b1;
                        s_d.done = 1'b1;
                        if (s_q.continuous_select) begin
                            s_d = begin_sample(s_d, 1'b0, ACQ_MAX);
                        end else begin
                            s_d.start = 1'b0;
                            s_d.st = cvd_pkg::ST_IDLE;
                            s_d.second = 1'b0;
                        end
                    end
                end
            end
            default: begin
                s_d.st = cvd_pkg::ST_IDLE;
            end
        endcase

        if (!s_q.on) begin
            s_d.st = cvd_pkg::ST_IDLE;
            s_d.ld = 1'b0;
            s_d.second = 1'b0;
        end

        if (s_q.on && (TRIGGER_I || RESTART_I)) begin
            s_d.start = 1'b1;
        end

        if (wr) begin
            case (ADR_I)
                `OFS_CTRL0: begin
                    if (SEL_I[0]) begin
                        s_d.on = DAT_I[`B_ON];
                        s_d.start = DAT_I[`B_START] | (s_d.start & ~s_q.start);
                        s_d.continuous_select = DAT_I[`B_CONTINUOUS_SELECT];
                        s_d.dbl = DAT_I[`B_DBL];
                    end
                end
                `OFS_CTRL1: begin
                    if (SEL_I[0]) begin
                        s_d.precharge_polarity = DAT_I[`B_PRECHARGE_POLARITY];
                        s_d.gpol = DAT_I[`B_GPOL];
                        s_d.inv = DAT_I[`B_INV];
                    end
                end
                `OFS_PRE: begin
                    if (SEL_I[0]) begin
                        s_d.pre = DAT_I[7:0];
                    end
                end
                `OFS_ACQ: begin
                    s_d.acq = acq_w[12:0];
                end
                `OFS_PUMP: begin
                    if (SEL_I[0]) begin
                        s_d.pump_en = DAT_I[`B_PUMP_EN];
                    end
                end
                `OFS_STAT: begin
                    if (SEL_I[0] && DAT_I[`B_DONE] && !set_done) begin
                        s_d.done = 1'b0;
                    end
                end
                `OFS_CHAN: begin
                    if (SEL_I[0] && DAT_I[5:0] != s_q.chan) begin
                        s_d.chan = DAT_I[5:0];
                        s_d.dirty = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (CYC_I && STB_I && !WE_I && !s_q.ack) begin
            case (ADR_I)
                `OFS_CTRL0: begin
                    s_d.dat[`B_ON] = s_q.on;
                    s_d.dat[`B_START] = s_q.start;
                    s_d.dat[`B_CONTINUOUS_SELECT] = s_q.continuous_select;
                    s_d.dat[`B_DBL] = s_q.dbl;
                end
                `OFS_CTRL1: begin
                    s_d.dat[`B_PRECHARGE_POLARITY] = s_q.precharge_polarity;
                    s_d.dat[`B_GPOL] = s_q.gpol;
                    s_d.dat[`B_INV] = s_q.inv;
                end
                `OFS_PRE: s_d.dat[7:0] = s_q.pre;
                `OFS_ACQ: s_d.dat[12:0] = s_q.acq;
                `OFS_PUMP: begin
                    s_d.dat[`B_PUMP_EN] = s_q.pump_en;
                    s_d.dat[`B_PUMP_RDY] = p_if.rdy;
                end
                `OFS_STAT: begin
                    s_d.dat[`B_DONE] = s_q.done;
                    s_d.dat[`B_BUSY] = (s_q.st != cvd_pkg::ST_IDLE);
                    s_d.dat[`B_SECOND] = s_q.second;
                end
                `OFS_CHAN: s_d.dat[5:0] = s_q.chan;
                default: begin
                end
            endcase
        end

        // hold cap is only ever tied during precharge, never discharged
        s_d.hold_pre = (s_d.st == cvd_pkg::ST_PRE);
        s_d.pin_lvl = ~s_d.pol;
        s_d.oe_n = (s_d.st != cvd_pkg::ST_PRE);
        s_d.connect = (s_d.st == cvd_pkg::ST_ACQ);
        s_d.convert = (s_d.st == cvd_pkg::ST_CONV);
    end

    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s_q <= '0;
            s_q.pre <= `RST_PRE;
            s_q.acq <= `RST_ACQ;
            s_q.chan <= `RST_CHAN;
            s_q.oe_n <= `RST_OE_N;
        end else begin
            s_q <= s_d;
        end
    end

    assign DAT_O = s_q.dat;
    assign ACK_O = s_q.ack;
    assign CHANNEL_O = s_q.chan;
    assign HOLD_PRECHARGE_O = s_q.hold_pre;
    assign HOLD_LEVEL_O = s_q.pol;
    assign CHANNEL_CONNECT_O = s_q.connect;
    assign CONVERT_O = s_q.convert;
    assign PIN_OUT_O = s_q.pin_lvl;
    assign PIN_OE_N_O = s_q.oe_n;
    assign GUARD_FIRST_O = s_q.ga;
    assign GUARD_SECOND_O = s_q.gb;
    assign PUMP_ON_O = s_q.pump_en;
    assign PUMP_READY_O = p_if.rdy;
    assign DONE_O = s_q.done;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    pre_enter_a: assert property (
        (s_q.st == cvd_pkg::ST_IDLE && s_q.on && s_q.start && s_q.pre != 8'h00) |=> s_q.st == cvd_pkg::ST_PRE)
        else $error("precharge not entered");
    pre_skip_a: assert property (
        (s_q.st == cvd_pkg::ST_IDLE && s_d.st != cvd_pkg::ST_IDLE && s_q.pre == 8'h00)
        |=> s_q.st != cvd_pkg::ST_PRE)
        else $error("precharge not skipped");
    pre_drive_a: assert property (
        (s_q.st == cvd_pkg::ST_PRE) |-> !PIN_OE_N_O && HOLD_PRECHARGE_O && !CHANNEL_CONNECT_O)
        else $error("precharge drive wrong");
    opposite_level_a: assert property (
        HOLD_PRECHARGE_O |-> PIN_OUT_O != HOLD_LEVEL_O)
        else $error("pin not opposite to hold level");
    acq_release_a: assert property (
        (s_q.st == cvd_pkg::ST_ACQ) |-> PIN_OE_N_O && CHANNEL_CONNECT_O && !HOLD_PRECHARGE_O)
        else $error("acquisition did not release pin");
    acq_max_a: assert property (
        (s_q.st == cvd_pkg::ST_PRE && t_if.done && s_q.acq == 13'h0000 && s_q.on) |-> t_if.len == ACQ_MAX)
        else $error("zero acquisition not maximal");
    guard_acq_a: assert property (
        (s_q.st == cvd_pkg::ST_PRE && t_if.done && s_q.on)
        |=> GUARD_FIRST_O != $past(GUARD_FIRST_O) && GUARD_SECOND_O == $past(GUARD_SECOND_O))
        else $error("guard outputs wrong at acquisition");
    second_inv_a: assert property (
        (s_q.st == cvd_pkg::ST_CONV && t_if.done && s_q.dbl && !s_q.second && s_q.on)
        |=> s_q.second && s_q.pol == !$past(s_q.precharge_polarity))
        else $error("second sample not inverted");
    done_set_a: assert property (
        (s_q.st == cvd_pkg::ST_CONV && t_if.done && s_q.on && (s_q.second || !s_q.dbl))
        |=> DONE_O && (s_q.start == ($past(s_q.continuous_select) || $past(TRIGGER_I || RESTART_I)
        || $past(wr && ADR_I == `OFS_CTRL0 && DAT_I[`B_START]))))
        else $error("completion flags wrong");
    conv_follow_a: assert property (
        (s_q.st == cvd_pkg::ST_ACQ && t_if.done && s_q.on) |=> CONVERT_O && !CHANNEL_CONNECT_O)
        else $error("conversion did not follow acquisition");
endmodule

/* File: tb/sensor_node_model.sv */
`timescale 1ns/1ps
module sensor_node_model (
    // clock and log clear
    input wire logic clk_i,
    input wire logic clr_i,
    // lines from the block
    input wire logic pin_out_i,
    input wire logic pin_oe_n_i,
    input wire logic hold_pre_i,
    input wire logic hold_lvl_i,
    input wire logic connect_i,
    input wire logic convert_i,
    input wire logic guard_first_i,
    input wire logic guard_second_i,
    // observations
    output logic node_o,
    output logic [15:0] pre_n_o,
    output logic [15:0] acq_n_o,
    output logic [15:0] conv_n_o,
    output logic [7:0] pre_log_o,
    output logic [7:0] acq_log_o,
    output logic [7:0] bad_o
);
    logic pre_q;
    logic acq_q;
    initial node_o = 1'b0;
    always @(posedge clk_i) begin
        pre_q <= hold_pre_i;
        acq_q <= connect_i;
        if (clr_i) begin
            {pre_n_o, acq_n_o, conv_n_o, pre_log_o, acq_log_o, bad_o} <= '0;
        end else begin
            // electrode keeps its charge once the pin driver lets go
            if (!pin_oe_n_i) node_o <= pin_out_i;
            if (hold_pre_i) pre_n_o <= pre_n_o + 16'h1;
            if (connect_i) acq_n_o <= acq_n_o + 16'h1;
            if (convert_i) conv_n_o <= conv_n_o + 16'h1;
            if (hold_pre_i && !pre_q) pre_log_o <= {pre_log_o[3:0], guard_first_i, guard_second_i, pin_out_i, hold_lvl_i};
            if (connect_i && !acq_q) acq_log_o <= {acq_log_o[5:0], guard_first_i, guard_second_i};
            if (hold_pre_i && (pin_oe_n_i || pin_out_i == hold_lvl_i)) bad_o <= bad_o + 8'h1;
            if ((connect_i && !pin_oe_n_i) || (convert_i && (connect_i || hold_pre_i))) bad_o <= bad_o + 8'h1;
        end
    end
endmodule

/* File: tb/cvd_sequencer_tb.sv */
`timescale 1ns/1ps
module cvd_sequencer_tb;
    localparam logic [12:0] ACQ_MAX_T = 13'h0014;
    logic CLK_I, RESETN_I, CYC_I, STB_I, WE_I, TRIGGER_I, RESTART_I, clr;
    logic [7:0] ADR_I;
    logic [3:0] SEL_I;
    logic [31:0] DAT_I, DAT_O, rd;
    logic ACK_O, HOLD_PRECHARGE_O, HOLD_LEVEL_O, CHANNEL_CONNECT_O, CONVERT_O, PIN_OUT_O, PIN_OE_N_O;
    logic GUARD_FIRST_O, GUARD_SECOND_O, PUMP_ON_O, PUMP_READY_O, DONE_O, node;
    logic [5:0] CHANNEL_O;
    logic [15:0] pre_n, acq_n, conv_n;
    logic [7:0] pre_log, acq_log, bad;
    int bad_count = 0;
    int num_checks = 0;

    cvd_sequencer #(.ACQ_MAX(ACQ_MAX_T)) i_cvd_sequencer (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CYC_I(CYC_I),
        .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .TRIGGER_I(TRIGGER_I), .RESTART_I(RESTART_I), .CHANNEL_O(CHANNEL_O), .HOLD_PRECHARGE_O(HOLD_PRECHARGE_O),
        .HOLD_LEVEL_O(HOLD_LEVEL_O), .CHANNEL_CONNECT_O(CHANNEL_CONNECT_O), .CONVERT_O(CONVERT_O),
        .PIN_OUT_O(PIN_OUT_O), .PIN_OE_N_O(PIN_OE_N_O), .GUARD_FIRST_O(GUARD_FIRST_O),
        .GUARD_SECOND_O(GUARD_SECOND_O), .PUMP_ON_O(PUMP_ON_O), .PUMP_READY_O(PUMP_READY_O), .DONE_O(DONE_O));

    sensor_node_model i_sensor_node_model (.clk_i(CLK_I), .clr_i(clr), .pin_out_i(PIN_OUT_O),
        .pin_oe_n_i(PIN_OE_N_O), .hold_pre_i(HOLD_PRECHARGE_O), .hold_lvl_i(HOLD_LEVEL_O),
        .connect_i(CHANNEL_CONNECT_O), .convert_i(CONVERT_O), .guard_first_i(GUARD_FIRST_O),
        .guard_second_i(GUARD_SECOND_O), .node_o(node), .pre_n_o(pre_n), .acq_n_o(acq_n), .conv_n_o(conv_n),
        .pre_log_o(pre_log), .acq_log_o(acq_log), .bad_o(bad));

    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I);
        {CYC_I, STB_I, WE_I, ADR_I, DAT_I} <= {2'b11, we, a, d};
        do begin
            @(posedge CLK_I);
        end while (ACK_O !== 1'b1);
        rd = DAT_O;
        {CYC_I, STB_I, WE_I} <= 3'b000;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // how: 0 start bit, 1 trigger line, 2 restart line
    task automatic run(input int how, input logic [31:0] ctl, input logic [31:0] ectl, input logic [15:0] ep,
                       input logic [15:0] ea, input logic [15:0] ec, input logic [7:0] epl, input logic [7:0] eal);
        int n;
        n = 0;
        @(posedge CLK_I);
        clr <= 1'b1;
        @(posedge CLK_I);
        clr <= 1'b0;
        if (how == 0) wb(1'b1, 8'h00, ctl);
        else if (how == 1) TRIGGER_I <= 1'b1;
        else RESTART_I <= 1'b1;
        @(posedge CLK_I);
        {TRIGGER_I, RESTART_I} <= 2'b00;
        while (DONE_O !== 1'b1 && n < 3000) begin
            @(posedge CLK_I);
            n++;
        end
        chk({15'h0, DONE_O}, 16'h1);
        rchk(8'h00, ectl);
        chk({pre_n, acq_n}, {ep, ea});
        chk({conv_n, pre_log, acq_log}, {ec, epl, eal});
        chk({24'h0, bad}, 32'h0);
        wb(1'b1, 8'h14, 32'h1);
        rchk(8'h14, 32'h0);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #300us;
        bad_count++;
        print_verdict();
    end

    initial begin
        {RESETN_I, CYC_I, STB_I, WE_I, TRIGGER_I, RESTART_I, ADR_I, DAT_I} = '0;
        SEL_I = 4'hf;
        clr = 1'b1;
        repeat (20) @(posedge CLK_I);
        chk({DAT_O[31:12], CHANNEL_O, HOLD_PRECHARGE_O, HOLD_LEVEL_O, CHANNEL_CONNECT_O, CONVERT_O, PIN_OUT_O,
             PIN_OE_N_O}, 32'h1);
        chk({GUARD_FIRST_O, GUARD_SECOND_O, PUMP_ON_O, PUMP_READY_O, DONE_O, ACK_O}, 32'h0);
        RESETN_I <= 1'b1;
        wb(1'b1, 8'h40, 32'hffffffff);
        rchk(8'h40, 32'h0);
        rchk(8'h08, 32'h0);
        rchk(8'h0c, 32'h0);
        rchk(8'h18, 32'h0);
        wb(1'b1, 8'h10, 32'h1);
        @(posedge CLK_I);
        chk({31'h0, PUMP_ON_O}, 32'h1);
        repeat (50) @(posedge CLK_I);
        chk({31'h0, PUMP_READY_O}, 32'h0);
        repeat (60) @(posedge CLK_I);
        chk({31'h0, PUMP_READY_O}, 32'h1);
        rchk(8'h10, 32'h3);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h04, 32'h1);
        wb(1'b1, 8'h08, 32'h2);
        wb(1'b1, 8'h0c, 32'h3);
        run(0, 32'h3, 32'h1, 16'd2, 16'd3, 16'd15, 8'h01, 8'h02);
        wb(1'b1, 8'h04, 32'h5);
        run(0, 32'hb, 32'h9, 16'd4, 16'd6, 16'd30, 8'h1e, 8'h09);
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b1, 8'h0c, 32'h0);
        run(0, 32'h3, 32'h1, 16'd2, {3'h0, ACQ_MAX_T}, 16'd15, 8'h0d, 8'h01);
        wb(1'b1, 8'h08, 32'h0);
        run(1, 32'h0, 32'h1, 16'd0, 16'd0, 16'd15, 8'h00, 8'h00);
        wb(1'b1, 8'h18, 32'h5);
        @(posedge CLK_I);
        chk({26'h0, CHANNEL_O}, 32'h5);
        run(2, 32'h0, 32'h1, 16'd0, {3'h0, ACQ_MAX_T}, 16'd15, 8'h00, 8'h01);
        // continuous mode keeps start set across completions until software stops it
        wb(1'b1, 8'h00, 32'h7);
        while (DONE_O !== 1'b1) @(posedge CLK_I);
        rchk(8'h00, 32'h7);
        wb(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge CLK_I);
        rchk(8'h00, 32'h1);
        rchk(8'h14, 32'h1);
        wb(1'b1, 8'h14, 32'h1);
        chk({31'h0, node}, 32'h0);
        wb(1'b1, 8'h10, 32'h0);
        rchk(8'h10, 32'h0);
        print_verdict();
    end
endmodule
